// [bench/mct_pin_model.sv]
// Purpose: Far-side model that drives the capture pins
// Assumes: Pins change only on a rising clock edge, on request
// Notes: Each set flip bit toggles its pin once
module mct_pin_model (
  input wire logic i_clock,
  input wire logic i_nrst,
  input wire logic [3:0] i_flip,
  output logic [3:0] o_pin
);
  timeunit 1ns;
  timeprecision 100ps;
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      o_pin <= 4'h0;
    end else begin
      o_pin <= o_pin ^ i_flip;
    end
  end
endmodule : mct_pin_model

// [bench/mct_timer_tb.sv]
// Purpose: Self-checking bench for the match and capture timer
// Assumes: Prescale 0 gives one count per enabled cycle
// Notes: Events are checked against a queue of expected notes
module mct_timer_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import mct_pkg::*;
  typedef struct {logic cap; int ch; logic out; logic [31:0] val;} mct_note_t;
  logic clock, nrst, enable, cnt_rst, pause, running;
  logic [31:0] prescale, count, ps_count;
  logic [127:0] match_value, cap_value;
  logic [7:0] match_action;
  logic [3:0] match_reset, match_stop, match_irq, flip, cap_pins, cap_rise, cap_fall, cap_irq;
  logic [3:0] match_out, match_evt, cap_evt;
  int mismatches, n_compared, k;
  mct_note_t notes[$];
  mct_note_t nt;
  mct_pin_model pins (.i_clock(clock), .i_nrst(nrst), .i_flip(flip), .o_pin(cap_pins));
  mct_timer dut (.i_clock(clock), .i_nrst(nrst), .i_enable(enable), .i_counter_reset(cnt_rst),
    .i_pause(pause), .i_prescale(prescale), .i_match_value(match_value),
    .i_match_action(match_action), .i_match_reset(match_reset), .i_match_stop(match_stop),
    .i_match_irq_en(match_irq), .i_capture_input(cap_pins), .i_capture_rise(cap_rise),
    .i_capture_fall(cap_fall), .i_capture_irq_en(cap_irq), .o_count(count),
    .o_prescale_count(ps_count), .o_match_output(match_out), .o_match_event(match_evt),
    .o_capture_event(cap_evt), .o_capture_value(cap_value), .o_running(running));
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  task automatic check_val(string what, logic [31:0] exp, logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : check_val
  task automatic check_bit(string what, logic exp, logic got);
    check_val(what, {31'h0, exp}, {31'h0, got});
  endtask : check_bit
  task automatic step(int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : step
  task automatic run_for(int n);
    cnt_rst = 1'b1;
    step(1);
    cnt_rst = 1'b0;
    enable = 1'b1;
    step(n);
    enable = 1'b0;
  endtask : run_for
  task automatic give_verdict();
    if (mismatches == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : give_verdict
  // ----------------------------------------
  // Event monitor
  // ----------------------------------------
  always @(negedge clock) begin
    for (int i = 0; i < NUM_CH; i++) begin
      if (match_evt[i] === 1'b1 || cap_evt[i] === 1'b1) begin
        if (notes.size() == 0) begin
          check_val("unexpected event", 32'h0, 32'h1);
        end else begin
          nt = notes.pop_front();
          check_val("event channel", nt.ch, i);
          check_bit("event kind", nt.cap, cap_evt[i]);
          if (nt.cap) begin
            check_val("capture value", nt.val, cap_value[32*i+:32]);
          end else begin
            check_bit("match output", nt.out, match_out[i]);
            check_val("count at match", nt.val, count);
          end
        end
      end
    end
  end
  initial begin
    #300000;
    mismatches++;
    give_verdict();
  end
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    {nrst, enable, cnt_rst, pause, flip, cap_rise, cap_fall, cap_irq} = '0;
    {match_value, match_action, match_reset, match_stop, match_irq, prescale} = '0;
    void'($urandom(32'hB8E9));
    repeat (16) @(posedge clock);
    #1 nrst = 1'b1;
    step(1);
    check_val("count after reset", CNT_RST, count);
    check_val("pins after reset", 32'h0, {28'h0, match_out});
    for (int p = 0; p < 3; p++) begin
      prescale = $urandom_range(1, 6);
      k = $urandom_range(1, 5);
      run_for(k * (prescale + 1));
      check_val("count", k, count);
      check_val("prescale count", 32'h0, ps_count);
      check_bit("running", 1'b1, running);
    end
    prescale = 32'hFFFF_FFFF;
    run_for(5);
    check_val("prescale count", 32'h5, ps_count);
    check_val("count", 32'h0, count);
    prescale = 32'h0;
    pause = 1'b1;
    step(3);
    run_for(6);
    check_val("paused count", 32'h0, count);
    check_bit("paused running", 1'b0, running);
    pause = 1'b0;
    step(3);
    match_value = {32'h9, 32'h7, 32'h5, 32'h3};
    match_action = {ACT_TOGGLE, ACT_HIGH, ACT_LOW, ACT_NONE};
    match_reset = 4'h8;
    match_irq = 4'hF;
    for (int r = 0; r < 2; r++) begin
      for (int i = 0; i < NUM_CH; i++) begin
        notes.push_back('{1'b0, i, (i == 2) || (i == 3 && r == 0), (i == 3) ? 0 : 4 + 2 * i});
      end
    end
    run_for(20);
    step(2);
    match_reset = 4'h0;
    match_stop = 4'h2;
    notes.push_back('{1'b0, 0, 1'b0, 32'h4});
    notes.push_back('{1'b0, 1, 1'b0, 32'h6});
    run_for(12);
    check_val("stopped count", 32'h6, count);
    check_bit("running", 1'b0, running);
    {match_stop, match_irq} = '0;
    {cap_rise, cap_fall, cap_irq} = 12'hFA7;
    for (int c = 0; c < NUM_CH; c++) begin
      k = $urandom_range(1, 40);
      run_for(k);
      if (cap_irq[c]) begin
        notes.push_back('{1'b1, c, 1'b0, k});
      end
      flip[c] = 1'b1;
      step(1);
      flip = 4'h0;
      step(8);
      check_val("captured count", k, cap_value[32*c+:32]);
      if (cap_irq[c] && cap_fall[c]) begin
        notes.push_back('{1'b1, c, 1'b0, k});
      end
      flip[c] = 1'b1;
      step(1);
      flip = 4'h0;
      step(8);
    end
    check_val("pending notes", 32'h0, notes.size());
    give_verdict();
  end
endmodule : mct_timer_tb

// [logic/mct_capture_chan.sv]
// Purpose: One capture channel: pin synchroniser, edge detect, counter snapshot
// Assumes: Capture pin is asynchronous to i_clock
// Notes: First synchroniser stage feeds only the second stage
module mct_capture_chan #(
  parameter int WIDTH = 32
) (
  input wire logic i_clock,
  input wire logic i_nrst,
  input wire logic i_pin,
  input wire logic i_rise_en,
  input wire logic i_fall_en,
  input wire logic [WIDTH-1:0] i_count,
  output logic [WIDTH-1:0] o_value,
  output logic o_event
);
  import mct_pkg::*;

  logic meta_q;
  logic sync_q;
  logic last_q;
  logic hit;

  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      last_q <= 1'b0;
    end else begin
      meta_q <= i_pin;
      sync_q <= meta_q;
      last_q <= sync_q;
    end
  end

  assign hit = (i_rise_en && sync_q && !last_q) || (i_fall_en && !sync_q && last_q);

  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      o_value <= '0;
      o_event <= 1'b0;
    end else begin
      o_event <= hit;
      if (hit) begin
        o_value <= i_count;
      end
    end
  end

  chk_capture_snap: assert property (@(posedge i_clock) disable iff (!i_nrst)
    hit |=> (o_value == $past(i_count) && o_event)) else $error("capture missed");
endmodule : mct_capture_chan

// [logic/mct_pkg.sv]
// Purpose: Shared constants for the match and capture timer
// Assumes: One clock domain, counters advance on a count enable
// Notes: Action encodings and reset values are shared by core and bench
package mct_pkg;
  localparam int CNT_W = 32;
  localparam int NUM_CH = 4;
  // Match output actions
  localparam logic [1:0] ACT_NONE = 2'h0;
  localparam logic [1:0] ACT_LOW = 2'h1;
  localparam logic [1:0] ACT_HIGH = 2'h2;
  localparam logic [1:0] ACT_TOGGLE = 2'h3;
  // Reset values and synchroniser depth
  localparam logic [CNT_W-1:0] CNT_RST = 32'h0000_0000;
  localparam logic MATCH_OUT_RST = 1'b0;
  localparam int SYNC_STAGES = 2;
endpackage : mct_pkg

// [logic/mct_timer.sv]
// Purpose: Match and capture timer with 32-bit prescaler and timer counter
// Assumes: Single clock i_clock stands for the timer count clock
// Notes: Configuration arrives as plain ports, no software registers
module mct_timer #(
  parameter int WIDTH = 32,
  parameter int CHANNELS = 4,
  parameter bit HAS_PAUSE = 1'b1
) (
  input wire logic i_clock,
  input wire logic i_nrst,
  input wire logic i_enable,
  input wire logic i_counter_reset,
  input wire logic i_pause,
  input wire logic [WIDTH-1:0] i_prescale,
  input wire logic [CHANNELS*WIDTH-1:0] i_match_value,
  input wire logic [CHANNELS*2-1:0] i_match_action,
  input wire logic [CHANNELS-1:0] i_match_reset,
  input wire logic [CHANNELS-1:0] i_match_stop,
  input wire logic [CHANNELS-1:0] i_match_irq_en,
  input wire logic [CHANNELS-1:0] i_capture_input,
  input wire logic [CHANNELS-1:0] i_capture_rise,
  input wire logic [CHANNELS-1:0] i_capture_fall,
  input wire logic [CHANNELS-1:0] i_capture_irq_en,
  output logic [WIDTH-1:0] o_count,
  output logic [WIDTH-1:0] o_prescale_count,
  output logic [CHANNELS-1:0] o_match_output,
  output logic [CHANNELS-1:0] o_match_event,
  output logic [CHANNELS-1:0] o_capture_event,
  output logic [CHANNELS*WIDTH-1:0] o_capture_value,
  output logic o_running
);
  import mct_pkg::*;

  // ------------------------------------------------------------
  // Pause synchroniser and count enable
  // ------------------------------------------------------------
  logic pause_meta_q;
  logic pause_sync_q;
  logic stop_q;
  logic tick;
  logic [CHANNELS-1:0] hit;
  logic [CHANNELS-1:0] cap_evt;

  function automatic logic out_next(input logic cur, input logic [1:0] act);
    case (act)
      ACT_LOW: out_next = 1'b0;
      ACT_HIGH: out_next = 1'b1;
      ACT_TOGGLE: out_next = ~cur;
      default: out_next = cur;
    endcase
  endfunction : out_next

  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      pause_meta_q <= 1'b0;
      pause_sync_q <= 1'b0;
    end else begin
      pause_meta_q <= i_pause;
      pause_sync_q <= pause_meta_q;
    end
  end

  logic run;
  assign run = i_enable && !stop_q && !(HAS_PAUSE && pause_sync_q);
  assign tick = run && (o_prescale_count >= i_prescale);

  // ------------------------------------------------------------
  // Prescaler and timer counter
  // ------------------------------------------------------------
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      o_prescale_count <= CNT_RST;
    end else if (i_counter_reset) begin
      o_prescale_count <= CNT_RST;
    end else if (tick) begin
      o_prescale_count <= CNT_RST;
    end else if (run) begin
      o_prescale_count <= o_prescale_count + 1'b1;
    end
  end

  // Matches are evaluated on the tick so each value fires once per pass
  always_comb begin
    for (int i = 0; i < CHANNELS; i++) begin
      hit[i] = tick && (o_count == i_match_value[i*WIDTH +: WIDTH]);
    end
  end

  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      o_count <= CNT_RST;
    end else if (i_counter_reset) begin
      o_count <= CNT_RST;
    end else if (|(hit & i_match_reset)) begin
      o_count <= CNT_RST;
    end else if (tick) begin
      o_count <= o_count + 1'b1;
    end
  end

  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      stop_q <= 1'b0;
    end else if (|(hit & i_match_stop)) begin
      stop_q <= 1'b1;
    end else if (i_counter_reset) begin
      stop_q <= 1'b0;
    end
  end

  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      o_running <= 1'b0;
    end else begin
      o_running <= run;
    end
  end

  // ------------------------------------------------------------
  // Match outputs and events
  // ------------------------------------------------------------
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      o_match_output <= {CHANNELS{MATCH_OUT_RST}};
      o_match_event <= '0;
    end else begin
      for (int i = 0; i < CHANNELS; i++) begin
        o_match_event[i] <= hit[i] && i_match_irq_en[i];
        if (hit[i]) begin
          o_match_output[i] <= out_next(o_match_output[i], i_match_action[i*2 +: 2]);
        end
      end
    end
  end

  // ------------------------------------------------------------
  // Capture channels
  // ------------------------------------------------------------
  for (genvar g = 0; g < CHANNELS; g++) begin : g_cap
    logic cap_raw;
    mct_capture_chan #(.WIDTH(WIDTH)) u_cap (
      .i_clock(i_clock),
      .i_nrst(i_nrst),
      .i_pin(i_capture_input[g]),
      .i_rise_en(i_capture_rise[g]),
      .i_fall_en(i_capture_fall[g]),
      .i_count(o_count),
      .o_value(o_capture_value[g*WIDTH +: WIDTH]),
      .o_event(cap_raw)
    );
    assign cap_evt[g] = cap_raw;
  end

  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      o_capture_event <= '0;
    end else begin
      o_capture_event <= cap_evt & i_capture_irq_en;
    end
  end

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  chk_prescale_wrap: assert property (@(posedge i_clock) disable iff (!i_nrst)
    (tick && !i_counter_reset) |=> (o_prescale_count == '0)) else $error("prescale no wrap");
  chk_count_step: assert property (@(posedge i_clock) disable iff (!i_nrst)
    (tick && !i_counter_reset && !(|(hit & i_match_reset)))
    |=> (o_count == $past(o_count) + 1'b1)) else $error("count no step");
  chk_count_hold: assert property (@(posedge i_clock) disable iff (!i_nrst)
    (!tick && !i_counter_reset) |=> $stable(o_count)) else $error("count moved");
  chk_pause_halt: assert property (@(posedge i_clock) disable iff (!i_nrst)
    (HAS_PAUSE && pause_sync_q && !i_counter_reset) |=> $stable(o_prescale_count))
    else $error("pause ignored");
  chk_match_reset: assert property (@(posedge i_clock) disable iff (!i_nrst)
    (|(hit & i_match_reset)) |=> (o_count == '0)) else $error("no match reset");
  chk_match_stop: assert property (@(posedge i_clock) disable iff (!i_nrst)
    (|(hit & i_match_stop)) |=> ##1 !o_running) else $error("no match stop");
  // Output actions and events are checked on every channel
  for (genvar g = 0; g < CHANNELS; g++) begin : g_chk
    chk_match_toggle: assert property (@(posedge i_clock) disable iff (!i_nrst)
      (hit[g] && i_match_action[g*2 +: 2] == ACT_TOGGLE)
      |=> (o_match_output[g] != $past(o_match_output[g]))) else $error("no toggle");
    chk_match_low: assert property (@(posedge i_clock) disable iff (!i_nrst)
      (hit[g] && i_match_action[g*2 +: 2] == ACT_LOW)
      |=> !o_match_output[g]) else $error("no low");
    chk_match_high: assert property (@(posedge i_clock) disable iff (!i_nrst)
      (hit[g] && i_match_action[g*2 +: 2] == ACT_HIGH)
      |=> o_match_output[g]) else $error("no high");
    chk_match_event: assert property (@(posedge i_clock) disable iff (!i_nrst)
      (hit[g] && i_match_irq_en[g]) |=> o_match_event[g]) else $error("no match event");
  end

  cov_match_hit: cover property (@(posedge i_clock) disable iff (!i_nrst) |hit);
  cov_capture: cover property (@(posedge i_clock) disable iff (!i_nrst) |o_capture_event);
  cov_stop: cover property (@(posedge i_clock) disable iff (!i_nrst) stop_q);
  cov_pause: cover property (@(posedge i_clock) disable iff (!i_nrst) pause_sync_q && i_enable);
endmodule : mct_timer
